// *** src/pri_consts.vh ***
`ifndef PRI_CONSTS_VH
`define PRI_CONSTS_VH
// loop timing, derived from the 10 MHz clock and the 3,200 pps strobe stream
`define PRI_CLK_HZ          32'h00989680
`define PRI_STROBE_PPS      32'h00000C80
// one strobe period in clock cycles (312.5 us at 100 ns)
`define PRI_PERIOD_CYC      (`PRI_CLK_HZ / `PRI_STROBE_PPS)
// selection intervals per loop cycle at zero input (3 up, 3 down)
`define PRI_CYCLE_SLOTS     3'h6
`define PRI_HALF_SLOTS      3'h3
// saturation point of the run counter of the slot check
`define PRI_RUN_MAX         3'h7
// reset values: plus state drives the float toward null from rest
`define PRI_DIR_RST         1'h1
`define PRI_SW_RST          1'h1
// mode encoding of the configuration input
`define PRI_MODE_ACCEL      1'h0
`define PRI_MODE_GYRO       1'h1
`endif

// *** src/pri_interrogator.v ***
`include "pri_consts.vh"
`default_nettype none

// two-flop synchroniser with an optional rising-edge detect; the first
// flop is read only by the second so a metastable value never fans out
module pri_sync_stage #(
  parameter EDGE = 0
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire raw_in,
  output wire sync_out
);

  reg meta_ff;
  reg stable_ff;
  reg prev_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'h0;
    end else begin
      meta_ff <= raw_in;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_ff <= 1'h0;
    end else begin
      stable_ff <= meta_ff;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'h0;
    end else begin
      prev_ff <= stable_ff;
    end
  end

  // idle strobes are low, so the zero reset of prev_ff gives no false edge
  assign sync_out = (EDGE != 0) ? (stable_ff & ~prev_ff)
                                : stable_ff;

endmodule // pri_sync_stage

// Overview of operation
// - zero-phase gated by strobe sets, pi-phase gated resets direction.
// - zero-phase peak means positive angle, pi-phase peak negative.
// - repeated set pulses keep the direction flip-flop in plus.
// - phase reversal at null issues reset, moving direction to minus.
// - accel mode: current switch changes only on a strobe when phase demands.
// - accel mode: exactly one torque winding energized, chosen by switch state.
// - flip-flops start in a defined state driving float toward null.
// - two-state mode: one winding always driven, no idle state.
// - winding selection updated at 3,200 decisions per second.
// - zero input gives three plus then three minus intervals.
// - excitation stays synchronous with computer clock and strobes.
// - accelerometer mode: plus switch drives plus winding, minus minus.
// - gyro mode disables accel gating; plus switch feeds gyro winding.
// - gyro plus-angle select drives negative winding, minus the reverse.
// - each switch strobe enables exactly one torque-set output.
// - switch state gated with data strobe returns plus or minus count.
module pri_interrogator (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire interrogate_strobe,
  input  wire switch_strobe,
  input  wire data_strobe,
  input  wire zero_phase_cmp,
  input  wire pi_phase_cmp,
  input  wire gyro_mode,
  input  wire gyro_plus_select,
  input  wire gyro_minus_select,
  output reg  plus_torque_set_strobe,
  output reg  minus_torque_set_strobe,
  output reg  plus_winding_drive,
  output reg  minus_winding_drive,
  output reg  gyro_neg_winding_drive,
  output reg  gyro_pos_winding_drive,
  output reg  dummy_load_drive,
  output reg  plus_count_pulse,
  output reg  minus_count_pulse,
  output reg  direction_plus,
  output reg  slot_error
);

  // strobe events and comparator levels, all two flops behind the pins
  wire ip_evt;
  wire sw_evt;
  wire ds_evt;
  wire zp_lvl;
  wire pp_lvl;
  wire mode_lvl;

  pri_sync_stage #(.EDGE(1)) ip_sync_u (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .raw_in   (interrogate_strobe),
    .sync_out (ip_evt)
  );

  pri_sync_stage #(.EDGE(1)) sw_sync_u (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .raw_in   (switch_strobe),
    .sync_out (sw_evt)
  );

  pri_sync_stage #(.EDGE(1)) ds_sync_u (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .raw_in   (data_strobe),
    .sync_out (ds_evt)
  );

  pri_sync_stage #(.EDGE(0)) zp_sync_u (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .raw_in   (zero_phase_cmp),
    .sync_out (zp_lvl)
  );

  pri_sync_stage #(.EDGE(0)) pp_sync_u (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .raw_in   (pi_phase_cmp),
    .sync_out (pp_lvl)
  );

  pri_sync_stage #(.EDGE(0)) mode_sync_u (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .raw_in   (gyro_mode),
    .sync_out (mode_lvl)
  );

  // comparators pass the same two flops as the strobe, so the level seen
  // with the event is the one present at the strobe's edge
  wire gyro_on = (mode_lvl == `PRI_MODE_GYRO);

  // comparators are sampled only at the strobe: their level at the 90 degree
  // peak carries the sign of the float angle; both equal is ignored
  wire set_pulse   = ip_evt & zp_lvl & ~pp_lvl;
  wire reset_pulse = ip_evt & pp_lvl & ~zp_lvl;

  // direction flip-flop of the interrogator
  reg dir_ff;
  reg nxt_dir;

  always @* begin
    nxt_dir = dir_ff;
    if (set_pulse) begin
      nxt_dir = 1'h1;
    end else if (reset_pulse) begin
      nxt_dir = 1'h0;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff <= `PRI_DIR_RST;
    end else begin
      dir_ff <= nxt_dir;
    end
  end

  // current-switch flip-flop, moved in accel mode only by the torque-set strobes,
  // which exist once per interrogate cycle; in gyro mode it follows the selects
  reg sw_ff;
  reg nxt_sw;
  reg nxt_tp;
  reg nxt_tm;

  always @* begin
    nxt_tp = sw_evt & dir_ff;
    nxt_tm = sw_evt & ~dir_ff;
    nxt_sw = sw_ff;
    if (gyro_on) begin
      // accel-only gating is off: the switch is on while a select is held
      nxt_sw = gyro_plus_select | gyro_minus_select;
    end else if (nxt_tp) begin
      nxt_sw = 1'h1;
    end else if (nxt_tm) begin
      nxt_sw = 1'h0;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_ff <= `PRI_SW_RST;
    end else begin
      sw_ff <= nxt_sw;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      plus_torque_set_strobe  <= 1'h0;
      minus_torque_set_strobe <= 1'h0;
    end else begin
      plus_torque_set_strobe  <= nxt_tp;
      minus_torque_set_strobe <= nxt_tm;
    end
  end

  // winding drives follow the switch one clock later; in accel mode one of
  // the pair is always on, so the loop has no idle third state
  reg nxt_plus_wind;
  reg nxt_minus_wind;
  reg nxt_gneg_wind;
  reg nxt_gpos_wind;
  reg nxt_dummy;

  always @* begin
    nxt_plus_wind  = ~gyro_on & sw_ff;
    nxt_minus_wind = ~gyro_on & ~sw_ff;
    // plus select wins when both selects are held
    nxt_gneg_wind  = gyro_on & sw_ff & gyro_plus_select;
    nxt_gpos_wind  = gyro_on & sw_ff & ~gyro_plus_select
                     & gyro_minus_select;
    // the minus side only keeps current flowing through the dummy load
    nxt_dummy      = gyro_on & ~sw_ff;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      plus_winding_drive     <= 1'h0;
      minus_winding_drive    <= 1'h0;
      gyro_neg_winding_drive <= 1'h0;
      gyro_pos_winding_drive <= 1'h0;
      dummy_load_drive       <= 1'h0;
    end else begin
      plus_winding_drive     <= nxt_plus_wind;
      minus_winding_drive    <= nxt_minus_wind;
      gyro_neg_winding_drive <= nxt_gneg_wind;
      gyro_pos_winding_drive <= nxt_gpos_wind;
      dummy_load_drive       <= nxt_dummy;
    end
  end

  // count pulses back to the computer, one per data strobe
  reg nxt_pcount;
  reg nxt_mcount;

  always @* begin
    nxt_pcount = ds_evt & sw_ff;
    nxt_mcount = ds_evt & ~sw_ff;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      plus_count_pulse  <= 1'h0;
      minus_count_pulse <= 1'h0;
    end else begin
      plus_count_pulse  <= nxt_pcount;
      minus_count_pulse <= nxt_mcount;
    end
  end

  // direction shown outside, one clock behind the flip-flop
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      direction_plus <= 1'h0;
    end else begin
      direction_plus <= dir_ff;
    end
  end

  // zero-input slot check: a run of one switch state longer than three
  // selection intervals is flagged; under acceleration this is expected,
  // so the flag is a diagnostic and never steers the loop
  reg [2:0] run_ff;
  reg [2:0] nxt_run;
  reg       last_sw_ff;
  reg       nxt_last_sw;
  reg       nxt_slot_err;

  always @* begin
    nxt_run      = run_ff;
    nxt_last_sw  = last_sw_ff;
    nxt_slot_err = slot_error;
    if (ds_evt && !gyro_on) begin
      nxt_last_sw = sw_ff;
      if (sw_ff != last_sw_ff) begin
        nxt_run = 3'h1;
      end else if (run_ff != `PRI_RUN_MAX) begin
        nxt_run = run_ff + 3'h1;
      end
      nxt_slot_err = (sw_ff == last_sw_ff) &&
                     (run_ff >= `PRI_HALF_SLOTS);
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff     <= 3'h0;
      last_sw_ff <= `PRI_SW_RST;
      slot_error <= 1'h0;
    end else begin
      run_ff     <= nxt_run;
      last_sw_ff <= nxt_last_sw;
      slot_error <= nxt_slot_err;
    end
  end

endmodule // pri_interrogator
`default_nettype wire

// *** test/pri_computer_model.sv ***
`include "pri_consts.vh"
`default_nettype none
module pri_computer_model (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic plus_count_pulse,
  input  wire logic minus_count_pulse,
  output var  logic interrogate_strobe,
  output var  logic switch_strobe,
  output var  logic data_strobe,
  output var  int   p_count,
  output var  int   n_count
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  initial {interrogate_strobe, switch_strobe, data_strobe} = 3'h0;
  // gap-free train locked to the clock
  always @(negedge ref_clk) begin
    cyc <= rst_n ? (cyc + 1) % `PRI_PERIOD_CYC : 0;
    interrogate_strobe <= rst_n && cyc < 20;
    switch_strobe <= rst_n && cyc >= 30 && cyc < 60;
    data_strobe <= rst_n && cyc >= 50 && cyc < 80;
  end
  always @(posedge ref_clk) p_count <= p_count + int'(plus_count_pulse);
  always @(posedge ref_clk) n_count <= n_count + int'(minus_count_pulse);
endmodule // pri_computer_model
`default_nettype wire

// *** test/pri_interrogator_assertions.sv ***
`default_nettype none
module pri_interrogator_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic interrogate_strobe,
  input wire logic switch_strobe,
  input wire logic zero_phase_cmp,
  input wire logic pi_phase_cmp,
  input wire logic gyro_mode,
  input wire logic direction_plus,
  input wire logic plus_torque_set_strobe,
  input wire logic minus_torque_set_strobe,
  input wire logic plus_winding_drive,
  input wire logic minus_winding_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic z = zero_phase_cmp, pc = pi_phase_cmp, dp = direction_plus;
  wire logic tp = plus_torque_set_strobe, tm = minus_torque_set_strobe;
  wire logic wp = plus_winding_drive, wm = minus_winding_drive;
  wire logic gm = gyro_mode;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ip; $rose(interrogate_strobe); endsequence
  // the mode pin reaches the drives several clocks late
  sequence s_acc;
    !gm && !$past(gm) && !$past(gm, 2) && !$past(gm, 3) && !$past(gm, 4)
    && !$past(gm, 5) && $past(rst_n, 2);
  endsequence
  property p_set; s_ip ##0 (z && !pc) |-> ##4 dp; endproperty
  property p_clr; s_ip ##0 (pc && !z) |-> ##4 !dp; endproperty
  property p_hold; s_ip ##0 (z == pc) |-> ##4 $stable(dp); endproperty
  property p_one; s_acc |-> wp != wm; endproperty
  property p_ts; $rose(switch_strobe) |-> ##3 (tp != tm); endproperty
  property p_tsd; tp || tm |-> tp == dp; endproperty
  property p_tsx; tp |=> !tp; endproperty
  property p_sw; s_acc ##0 $changed(wp) |-> $past(tp || tm); endproperty
  a_set: assert property (p_set) else $error("no set");
  a_clr: assert property (p_clr) else $error("no reset");
  a_hold: assert property (p_hold) else $error("dir moved");
  a_one: assert property (p_one) else $error("winding");
  a_ts: assert property (p_ts) else $error("no torque set");
  a_tsd: assert property (p_tsd) else $error("torque sign");
  a_tsx: assert property (p_tsx) else $error("long pulse");
  a_sw: assert property (p_sw) else $error("switch moved");
endmodule // pri_interrogator_checker
bind pri_interrogator pri_interrogator_checker chk_u (.*);
`default_nettype wire

// *** test/pri_interrogator_tb.sv ***
`default_nettype none
module pri_interrogator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, zero_phase_cmp = 1, pi_phase_cmp = 0;
  logic gyro_mode = 0, gyro_plus_select = 0, gyro_minus_select = 0;
  logic interrogate_strobe, switch_strobe, data_strobe, direction_plus;
  logic plus_torque_set_strobe, minus_torque_set_strobe, slot_error;
  logic plus_winding_drive, minus_winding_drive, gyro_neg_winding_drive;
  logic gyro_pos_winding_drive, dummy_load_drive;
  logic plus_count_pulse, minus_count_pulse;
  int p_count, n_count, cycles = 0, fail_count = 0, checks_done = 0;
  wire logic [5:0] drv = {plus_winding_drive, minus_winding_drive,
    gyro_neg_winding_drive, gyro_pos_winding_drive, dummy_load_drive,
    direction_plus};
  // next inputs {zero, pi, mode, plus sel, minus sel}, then expected drives
  logic [10:0] plan [11] = '{11'h421, 11'h421, 11'h221, 11'h210, 11'h210,
    11'h610, 11'h010, 11'h190, 11'h148, 11'h104, 11'h102};
  pri_interrogator dut_u (.*);
  pri_computer_model host_u (.*);
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (cycles++ == 60000) print_verdict(1);
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) fail_count++;
    if (g !== e) $display("BAD %s exp %h got %h", nm, e, g);
  endtask
  task automatic step(logic [4:0] nxt, logic [5:0] e);
    @(posedge data_strobe);
    repeat (5) @(negedge ref_clk);
    chk("drives", {2'h0, e}, {2'h0, drv});
    {zero_phase_cmp, pi_phase_cmp, gyro_mode} <= nxt[4:2];
    {gyro_plus_select, gyro_minus_select} <= nxt[1:0];
  endtask
  task print_verdict(int extra);
    fail_count += extra;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    chk("reset", 8'h00, {2'h0, drv});
    rst_n <= 1'h1;
    repeat (2) @(negedge ref_clk);
    chk("power_up", 8'h21, {2'h0, drv});
    foreach (plan[i]) begin
      step(plan[i][10:6], plan[i][5:0]);
      if (i == 5) chk("cnt", 8'h33, {p_count[3:0], n_count[3:0]});
      if (i == 7) chk("slot", 8'h01, {7'h00, slot_error});
    end
    print_verdict(0);
  end
endmodule // pri_interrogator_tb
`default_nettype wire
